//--- rtl/akb_top.sv
// Purpose: Builds the IPv6 transport search key for the second-stage ACL
// Assumes: Parser and classifier results stable while LOOKUP_VALID is high
// Notes: Key appears one cycle after the lookup strobe
`timescale 1ns/1ps
`include "akb_params.svh"

module akb_top
  import akb_pkg::*;
#(
  parameter int NUM_PORTS = `AKB_PORT_W,
  parameter int NUM_RNG = `AKB_RNG_W
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic LOOKUP_VALID,
  input wire logic FIRST_LOOKUP,
  input wire logic [`AKB_PAG_W-1:0] POLICY_GROUP,
  input wire logic [3:0] INGRESS_PORT,
  input wire logic SRC_GUARD_HIT,
  input wire logic [47:0] DEST_MAC,
  input wire logic [1:0] QTAG_COUNT,
  input wire logic [`AKB_VID_W-1:0] CLASS_VID,
  input wire logic CLASS_DEI,
  input wire logic [`AKB_PCP_W-1:0] CLASS_PCP,
  input wire logic [`AKB_DSCP_W-1:0] CLASS_DSCP,
  input wire logic [7:0] HOP_LIMIT,
  input wire logic [`AKB_TOS_W-1:0] TRAFFIC_CLASS,
  input wire logic [`AKB_ADDR_W-1:0] IPV6_DEST_ADDR,
  input wire logic [`AKB_ADDR_W-1:0] IPV6_SRC_ADDR,
  input wire logic [7:0] NEXT_HEADER,
  input wire logic [`AKB_L4P_W-1:0] L4_DEST_PORT,
  input wire logic [`AKB_L4P_W-1:0] L4_SRC_PORT,
  input wire logic [31:0] TCP_SEQ,
  input wire logic [7:0] TCP_FLAGS,
  input wire logic IS_PTP,
  input wire logic [3:0] PTP_MSG_TYPE,
  input wire logic [7:0] PTP_FLAG_OCTET,
  input wire logic [`AKB_DOM_W-1:0] PTP_DOMAIN,
  input wire logic [`AKB_VER_W-1:0] PTP_VERSION,
  input wire logic [3*NUM_RNG-1:0] RANGE_TYPE,
  input wire logic [16*NUM_RNG-1:0] RANGE_LOW,
  input wire logic [16*NUM_RNG-1:0] RANGE_HIGH,
  output logic [`AKB_KEY_W-1:0] KEY,
  output logic KEY_VALID
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [NUM_PORTS-1:0] port_onehot(input logic [3:0] p);
    port_onehot = '0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (p == 4'(i)) begin
        port_onehot[i] = 1'b1;
      end
    end
  endfunction : port_onehot

  function automatic logic is_tcp_proto(input logic [7:0] nh);
    is_tcp_proto = (nh == `AKB_PROTO_TCP);
  endfunction : is_tcp_proto

  akb_state_t state_q;
  akb_state_t state_d;
  logic [`AKB_KEY_W-1:0] key_c;
  logic tcp_c;
  logic ptp_c;

  akb_fields_if fields ();

  assign tcp_c = is_tcp_proto(NEXT_HEADER);
  assign ptp_c = IS_PTP && !tcp_c;

  // ----------------------------------------
  // Fields for helper modules
  // ----------------------------------------
  assign fields.l4_src_port = L4_SRC_PORT;
  assign fields.l4_dest_port = L4_DEST_PORT;
  assign fields.vid = CLASS_VID;
  assign fields.dscp = CLASS_DSCP;
  assign fields.is_tcp = tcp_c;
  assign fields.is_ptp = ptp_c;
  assign fields.seq_zero = (TCP_SEQ == 32'h00000000);
  assign fields.tcp_flags = TCP_FLAGS;
  assign fields.ptp_msg_type = PTP_MSG_TYPE;
  assign fields.ptp_flag_octet = PTP_FLAG_OCTET;
  assign fields.ptp_domain = PTP_DOMAIN;
  assign fields.ptp_version = PTP_VERSION;

  akb_range #(
    .NUM_RNG(NUM_RNG)
  ) u_range (
    .f(fields.ranger),
    .rng_type(RANGE_TYPE),
    .rng_low(RANGE_LOW),
    .rng_high(RANGE_HIGH)
  );

  akb_l4 u_l4 (
    .f(fields.l4sel)
  );

  // ----------------------------------------
  // Key assembly
  // ----------------------------------------
  always_comb begin
    key_c = '0;
    key_c[`AKB_TYPE_LSB +: `AKB_TYPE_W] = `AKB_TYPE_TRANSPORT;
    key_c[`AKB_FIRST_BIT] = FIRST_LOOKUP;
    key_c[`AKB_PAG_LSB +: `AKB_PAG_W] = POLICY_GROUP;
    key_c[`AKB_PORT_LSB +: `AKB_PORT_W] = port_onehot(INGRESS_PORT);
    key_c[`AKB_RSVD_BIT] = 1'b0;
    key_c[`AKB_GUARD_BIT] = SRC_GUARD_HIT;
    key_c[`AKB_MC_BIT] = DEST_MAC[`AKB_MAC_GROUP_BIT];
    key_c[`AKB_BC_BIT] = (DEST_MAC == `AKB_MAC_BCAST);
    key_c[`AKB_TAG_BIT] = (QTAG_COUNT != 2'h0);
    key_c[`AKB_VID_LSB +: `AKB_VID_W] = CLASS_VID;
    key_c[`AKB_DEI_BIT] = CLASS_DEI;
    key_c[`AKB_PCP_LSB +: `AKB_PCP_W] = CLASS_PCP;
    key_c[`AKB_TTL_BIT] = (HOP_LIMIT != 8'h00);
    key_c[`AKB_TOS_LSB +: `AKB_TOS_W] = TRAFFIC_CLASS;
    key_c[`AKB_DIP_LSB +: `AKB_ADDR_W] = IPV6_DEST_ADDR;
    key_c[`AKB_SIP_LSB +: `AKB_ADDR_W] = IPV6_SRC_ADDR;
    key_c[`AKB_ADDR_EQ_BIT] = (IPV6_DEST_ADDR == IPV6_SRC_ADDR);
    key_c[`AKB_TCP_BIT] = tcp_c;
    key_c[`AKB_DPORT_LSB +: `AKB_L4P_W] = L4_DEST_PORT;
    key_c[`AKB_SPORT_LSB +: `AKB_L4P_W] = L4_SRC_PORT;
    key_c[`AKB_PORT_EQ_BIT] = (L4_DEST_PORT == L4_SRC_PORT);
    key_c[`AKB_RNG_LSB +: `AKB_RNG_W] = fields.range_hit_mask;
    key_c[`AKB_FLAGS_LSB +: `AKB_FLAGS_W] = fields.l4_flags;
    key_c[`AKB_DOM_LSB +: `AKB_DOM_W] = fields.dom_out;
    key_c[`AKB_VER_LSB +: `AKB_VER_W] = fields.ver_out;
  end

  // ----------------------------------------
  // State update
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.valid = LOOKUP_VALID;
    if (LOOKUP_VALID) begin
      state_d.key = key_c;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign KEY = state_q.key;
  assign KEY_VALID = state_q.valid;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  key_type_a: assert property (KEY_VALID |->
    KEY[`AKB_TYPE_LSB +: `AKB_TYPE_W] == `AKB_TYPE_TRANSPORT)
    else $error("key type code wrong");

  first_flag_a: assert property (LOOKUP_VALID |=>
    KEY_VALID && (KEY[`AKB_FIRST_BIT] == $past(FIRST_LOOKUP)))
    else $error("first lookup bit wrong");

  policy_group_a: assert property (KEY_VALID |->
    KEY[`AKB_PAG_LSB +: `AKB_PAG_W] == $past(POLICY_GROUP))
    else $error("policy group not copied");

  port_onehot_a: assert property (KEY_VALID && $past(INGRESS_PORT) < 4'hC |->
    KEY[`AKB_PORT_LSB +: `AKB_PORT_W] == (12'h001 << $past(INGRESS_PORT)))
    else $error("ingress port mask wrong");

  guard_hit_a: assert property (KEY_VALID |->
    KEY[`AKB_GUARD_BIT] == $past(SRC_GUARD_HIT))
    else $error("source guard bit wrong");

  mcast_flag_a: assert property (KEY_VALID |->
    KEY[`AKB_MC_BIT] == $past(DEST_MAC[`AKB_MAC_GROUP_BIT]))
    else $error("multicast bit wrong");

  bcast_flag_a: assert property (KEY_VALID |->
    KEY[`AKB_BC_BIT] == ($past(DEST_MAC) == `AKB_MAC_BCAST))
    else $error("broadcast bit wrong");

  qtag_flag_a: assert property (KEY_VALID |->
    KEY[`AKB_TAG_BIT] == ($past(QTAG_COUNT) != 2'h0))
    else $error("tag bit wrong");

  class_vlan_a: assert property (KEY_VALID |->
    KEY[`AKB_VID_LSB +: `AKB_VID_W] == $past(CLASS_VID) &&
    KEY[`AKB_DEI_BIT] == $past(CLASS_DEI))
    else $error("classified vlan fields wrong");

  hop_limit_a: assert property (KEY_VALID |->
    KEY[`AKB_TTL_BIT] == ($past(HOP_LIMIT) != 8'h00))
    else $error("hop limit bit wrong");

  addr_equal_a: assert property (KEY_VALID |->
    KEY[`AKB_ADDR_EQ_BIT] ==
    (KEY[`AKB_DIP_LSB +: `AKB_ADDR_W] == KEY[`AKB_SIP_LSB +: `AKB_ADDR_W]))
    else $error("address equal bit wrong");

  tcp_flag_a: assert property (KEY_VALID |->
    KEY[`AKB_TCP_BIT] == ($past(NEXT_HEADER) == `AKB_PROTO_TCP))
    else $error("tcp bit wrong");

  ports_equal_a: assert property (KEY_VALID |->
    KEY[`AKB_PORT_EQ_BIT] ==
    (KEY[`AKB_DPORT_LSB +: `AKB_L4P_W] == KEY[`AKB_SPORT_LSB +: `AKB_L4P_W]))
    else $error("port equal bit wrong");

  udp_zero_a: assert property (KEY_VALID && !KEY[`AKB_TCP_BIT] && !$past(IS_PTP) |->
    KEY[`AKB_FLAGS_LSB +: `AKB_FLAGS_W] == '0 && KEY[`AKB_DOM_LSB +: `AKB_DOM_W] == '0)
    else $error("plain udp flags not zero");

  ptp_domain_a: assert property (KEY_VALID && !KEY[`AKB_TCP_BIT] && $past(IS_PTP) |->
    KEY[`AKB_DOM_LSB +: `AKB_DOM_W] == $past(PTP_DOMAIN) &&
    KEY[`AKB_FLAGS_LSB] == $past(PTP_MSG_TYPE[0]))
    else $error("ptp fields wrong");

  ptp_version_a: assert property (KEY_VALID && !KEY[`AKB_TCP_BIT] && $past(IS_PTP) |->
    KEY[`AKB_VER_LSB +: `AKB_VER_W] == $past(PTP_VERSION))
    else $error("ptp version wrong");

  ptp_flags_a: assert property (KEY_VALID && !KEY[`AKB_TCP_BIT] && $past(IS_PTP) |->
    KEY[`AKB_FLAGS_LSB +: `AKB_FLAGS_W] == {$past(PTP_FLAG_OCTET[7]),
    $past(PTP_FLAG_OCTET[2]), $past(PTP_FLAG_OCTET[1]), $past(PTP_MSG_TYPE)})
    else $error("ptp flag bits wrong");

  tcp_flags_a: assert property (KEY_VALID && KEY[`AKB_TCP_BIT] |->
    KEY[`AKB_FLAGS_LSB +: `AKB_FLAGS_W] ==
    {$past(TCP_FLAGS[5:0]), ($past(TCP_SEQ) == 32'h00000000)})
    else $error("tcp flag bits wrong");

  tcp_no_ptp_a: assert property (KEY_VALID && KEY[`AKB_TCP_BIT] |->
    KEY[`AKB_DOM_LSB +: `AKB_DOM_W] == '0 && KEY[`AKB_VER_LSB +: `AKB_VER_W] == '0)
    else $error("tcp key carries ptp fields");

  class_pcp_a: assert property (KEY_VALID |->
    KEY[`AKB_PCP_LSB +: `AKB_PCP_W] == $past(CLASS_PCP))
    else $error("classified pcp wrong");

  traffic_class_a: assert property (KEY_VALID |->
    KEY[`AKB_TOS_LSB +: `AKB_TOS_W] == $past(TRAFFIC_CLASS))
    else $error("traffic class wrong");

  dest_addr_a: assert property (KEY_VALID |->
    KEY[`AKB_DIP_LSB +: `AKB_ADDR_W] == $past(IPV6_DEST_ADDR))
    else $error("destination address wrong");

  src_addr_a: assert property (KEY_VALID |->
    KEY[`AKB_SIP_LSB +: `AKB_ADDR_W] == $past(IPV6_SRC_ADDR))
    else $error("source address wrong");

  dest_port_a: assert property (KEY_VALID |->
    KEY[`AKB_DPORT_LSB +: `AKB_L4P_W] == $past(L4_DEST_PORT))
    else $error("destination port wrong");

  src_port_a: assert property (KEY_VALID |->
    KEY[`AKB_SPORT_LSB +: `AKB_L4P_W] == $past(L4_SRC_PORT))
    else $error("source port wrong");

  reserved_bit_a: assert property (KEY_VALID |-> !KEY[`AKB_RSVD_BIT])
    else $error("reserved bit not zero");

  range_off_a: assert property (KEY_VALID && $past(RANGE_TYPE) == '0 |->
    KEY[`AKB_RNG_LSB +: `AKB_RNG_W] == '0)
    else $error("range hit with checkers off");

  key_hold_a: assert property (KEY_VALID ##1 !KEY_VALID |-> $stable(KEY))
    else $error("key changed without lookup");

  tcp_lookup_c: cover property (KEY_VALID && KEY[`AKB_TCP_BIT]);
  ptp_lookup_c: cover property (KEY_VALID && !KEY[`AKB_TCP_BIT] && $past(IS_PTP));
  bcast_lookup_c: cover property (KEY_VALID && KEY[`AKB_BC_BIT]);
  range_hit_c: cover property (KEY_VALID && KEY[`AKB_RNG_LSB +: `AKB_RNG_W] != '0);
  b2b_lookup_c: cover property (KEY_VALID ##1 KEY_VALID);
endmodule : akb_top

//--- rtl/akb_params.svh
// Purpose: Field positions and constants of the IPv6 transport search key
// Assumes: Included by every file of the key builder
// Notes: Bit positions are key bit indices, LSB first
`ifndef AKB_PARAMS_SVH
`define AKB_PARAMS_SVH

// ----------------------------------------
// Key layout
// ----------------------------------------
`define AKB_KEY_W 371
`define AKB_TYPE_LSB 0
`define AKB_TYPE_W 2
`define AKB_FIRST_BIT 2
`define AKB_PAG_LSB 3
`define AKB_PAG_W 8
`define AKB_PORT_LSB 11
`define AKB_PORT_W 12
`define AKB_RSVD_BIT 23
`define AKB_GUARD_BIT 24
`define AKB_MC_BIT 25
`define AKB_BC_BIT 26
`define AKB_TAG_BIT 27
`define AKB_VID_LSB 28
`define AKB_VID_W 12
`define AKB_DEI_BIT 40
`define AKB_PCP_LSB 41
`define AKB_PCP_W 3
`define AKB_TTL_BIT 44
`define AKB_TOS_LSB 45
`define AKB_TOS_W 8
`define AKB_DIP_LSB 53
`define AKB_SIP_LSB 181
`define AKB_ADDR_W 128
`define AKB_ADDR_EQ_BIT 309
`define AKB_TCP_BIT 310
`define AKB_DPORT_LSB 311
`define AKB_SPORT_LSB 327
`define AKB_L4P_W 16
`define AKB_RNG_LSB 343
`define AKB_RNG_W 8
`define AKB_PORT_EQ_BIT 351
`define AKB_FLAGS_LSB 352
`define AKB_FLAGS_W 7
`define AKB_DOM_LSB 359
`define AKB_DOM_W 8
`define AKB_VER_LSB 367
`define AKB_VER_W 4

// ----------------------------------------
// Codes and values
// ----------------------------------------
`define AKB_TYPE_TRANSPORT 2'h0
`define AKB_TYPE_MISC 2'h1
`define AKB_TYPE_CUSTOM 2'h2
`define AKB_PROTO_TCP 8'h06
`define AKB_MAC_GROUP_BIT 40
`define AKB_MAC_BCAST 48'hFFFFFFFFFFFF
`define AKB_DSCP_W 6

`endif

//--- rtl/akb_pkg.sv
// Purpose: Types shared by the key builder modules
// Assumes: akb_params.svh supplies widths
// Notes: None
`include "akb_params.svh"
package akb_pkg;
  typedef enum logic [2:0] {
    AKB_RNG_OFF = 3'h0,
    AKB_RNG_SPORT = 3'h1,
    AKB_RNG_DPORT = 3'h2,
    AKB_RNG_EITHER = 3'h3,
    AKB_RNG_VID = 3'h4,
    AKB_RNG_DSCP = 3'h5
  } akb_rng_t;

  typedef struct packed {
    logic [`AKB_KEY_W-1:0] key;
    logic valid;
  } akb_state_t;
endpackage : akb_pkg

//--- rtl/akb_fields_if.sv
// Purpose: Frame fields passed from the key builder to its helpers
// Assumes: One clock domain, purely combinational use
// Notes: None
`timescale 1ns/1ps
`include "akb_params.svh"
interface akb_fields_if;
  logic [`AKB_L4P_W-1:0] l4_src_port;
  logic [`AKB_L4P_W-1:0] l4_dest_port;
  logic [`AKB_VID_W-1:0] vid;
  logic [`AKB_DSCP_W-1:0] dscp;
  logic is_tcp;
  logic is_ptp;
  logic seq_zero;
  logic [7:0] tcp_flags;
  logic [3:0] ptp_msg_type;
  logic [7:0] ptp_flag_octet;
  logic [`AKB_DOM_W-1:0] ptp_domain;
  logic [`AKB_VER_W-1:0] ptp_version;
  logic [`AKB_RNG_W-1:0] range_hit_mask;
  logic [`AKB_FLAGS_W-1:0] l4_flags;
  logic [`AKB_DOM_W-1:0] dom_out;
  logic [`AKB_VER_W-1:0] ver_out;

  modport builder (output l4_src_port, l4_dest_port, vid, dscp, is_tcp, is_ptp,
    seq_zero, tcp_flags, ptp_msg_type, ptp_flag_octet, ptp_domain, ptp_version,
    input range_hit_mask, l4_flags, dom_out, ver_out);
  modport ranger (input l4_src_port, l4_dest_port, vid, dscp,
    output range_hit_mask);
  modport l4sel (input is_tcp, is_ptp, seq_zero, tcp_flags, ptp_msg_type,
    ptp_flag_octet, ptp_domain, ptp_version, output l4_flags, dom_out, ver_out);
endinterface : akb_fields_if

//--- rtl/akb_range.sv
// Purpose: Range checkers feeding the range hit mask of the key
// Assumes: Checker setup held steady by the configuration logic
// Notes: A checker set to off never hits
`timescale 1ns/1ps
`include "akb_params.svh"
module akb_range
  import akb_pkg::*;
#(
  parameter int NUM_RNG = `AKB_RNG_W
) (
  akb_fields_if.ranger f,
  input wire logic [3*NUM_RNG-1:0] rng_type,
  input wire logic [16*NUM_RNG-1:0] rng_low,
  input wire logic [16*NUM_RNG-1:0] rng_high
);
  function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  // ----------------------------------------
  // One hit bit per checker
  // ----------------------------------------
  always_comb begin
    logic [15:0] lo;
    logic [15:0] hi;
    lo = 16'h0000;
    hi = 16'h0000;
    f.range_hit_mask = '0;
    for (int i = 0; i < NUM_RNG; i++) begin
      lo = rng_low[16*i +: 16];
      hi = rng_high[16*i +: 16];
      case (akb_rng_t'(rng_type[3*i +: 3]))
        AKB_RNG_SPORT: f.range_hit_mask[i] = in_range(f.l4_src_port, lo, hi);
        AKB_RNG_DPORT: f.range_hit_mask[i] = in_range(f.l4_dest_port, lo, hi);
        AKB_RNG_EITHER: f.range_hit_mask[i] = in_range(f.l4_src_port, lo, hi) ||
                                              in_range(f.l4_dest_port, lo, hi);
        AKB_RNG_VID: f.range_hit_mask[i] = in_range({4'h0, f.vid}, lo, hi);
        AKB_RNG_DSCP: f.range_hit_mask[i] = in_range({10'h000, f.dscp}, lo, hi);
        default: f.range_hit_mask[i] = 1'b0;
      endcase
    end
  end
endmodule : akb_range

//--- rtl/akb_l4.sv
// Purpose: Selects TCP or PTP meaning of the layer-4 flag bits
// Assumes: is_tcp and is_ptp never both high
// Notes: Plain UDP yields all zero
`timescale 1ns/1ps
`include "akb_params.svh"
module akb_l4
  import akb_pkg::*;
(
  akb_fields_if.l4sel f
);
  // ----------------------------------------
  // Flag bits, domain and version
  // ----------------------------------------
  always_comb begin
    f.l4_flags = '0;
    f.dom_out = '0;
    f.ver_out = '0;
    if (f.is_tcp) begin
      f.l4_flags[0] = f.seq_zero;
      f.l4_flags[1] = f.tcp_flags[0];
      f.l4_flags[2] = f.tcp_flags[1];
      f.l4_flags[3] = f.tcp_flags[2];
      f.l4_flags[4] = f.tcp_flags[3];
      f.l4_flags[5] = f.tcp_flags[4];
      f.l4_flags[6] = f.tcp_flags[5];
    end else if (f.is_ptp) begin
      f.l4_flags[0] = f.ptp_msg_type[0];
      f.l4_flags[1] = f.ptp_msg_type[1];
      f.l4_flags[2] = f.ptp_msg_type[2];
      f.l4_flags[3] = f.ptp_msg_type[3];
      f.l4_flags[4] = f.ptp_flag_octet[1];
      f.l4_flags[5] = f.ptp_flag_octet[2];
      f.l4_flags[6] = f.ptp_flag_octet[7];
      f.dom_out = f.ptp_domain;
      f.ver_out = f.ptp_version;
    end
  end
endmodule : akb_l4

//--- sim/akb_src.sv
// Purpose: Stand-in for the frame parser and first-stage classifier
// Assumes: Bench changes fields and strobe only at the falling clock edge
// Notes: Fields hold steady while the strobe is high, except in back-to-back lookups, which change them between strobed cycles
`timescale 1ns/1ps
`include "akb_params.svh"
module akb_src;
  logic lv, first, guard, dei, ptp;
  logic [7:0] policy_group, hop, tc, nh, flags, fo, dom;
  logic [3:0] port, msg, ver;
  logic [1:0] qtags;
  logic [47:0] dmac;
  logic [11:0] vid;
  logic [2:0] pcp;
  logic [5:0] dscp;
  logic [127:0] dip, sip, rlo, rhi;
  logic [15:0] dp, sp;
  logic [31:0] seq;
  logic [23:0] rtype;

  // ----------------------------------------
  // Idle frame
  // ----------------------------------------
  initial begin
    lv = 1'b0; first = 1'b1; guard = 1'b0; dei = 1'b1; ptp = 1'b0;
    policy_group = 8'hA5; hop = 8'h40; tc = 8'h3C; nh = 8'h11; flags = 8'h3F; fo = 8'h86;
    dom = 8'h2D; port = 4'h3; msg = 4'hB; ver = 4'h2; qtags = 2'h0;
    dmac = 48'h0A1B2C3D4E5F; vid = 12'h123; pcp = 3'h5; dscp = 6'h0A;
    dip = 128'h20010DB8000000000000000000000001;
    sip = 128'hFE800000000000000000000000000002;
    dp = 16'h0050; sp = 16'h1F90; seq = 32'h12345678;
    rtype = 24'h0; rlo = 128'h0; rhi = {8{16'hFFFF}};
  end

  // ----------------------------------------
  // Key the frame should produce
  // ----------------------------------------
  function automatic logic in_rng(logic [15:0] v, int i);
    return v >= rlo[16*i+:16] && v <= rhi[16*i+:16];
  endfunction : in_rng

  function automatic logic [`AKB_KEY_W-1:0] exp_key();
    logic [`AKB_KEY_W-1:0] e;
    logic tcp;
    logic [2:0] t;
    e = '0;
    tcp = nh == 8'h06;
    e[1:0] = `AKB_TYPE_TRANSPORT;
    e[2] = first;
    e[10:3] = policy_group;
    if (port < 4'hC) e[11 + port] = 1'b1;
    e[23] = 1'b0;
    e[24] = guard;
    e[25] = dmac[40];
    e[26] = dmac == 48'hFFFFFFFFFFFF;
    e[27] = qtags != 2'h0;
    e[39:28] = vid;
    e[40] = dei;
    e[43:41] = pcp;
    e[44] = hop != 8'h00;
    e[52:45] = tc;
    e[180:53] = dip;
    e[308:181] = sip;
    e[309] = dip == sip;
    e[310] = tcp;
    e[326:311] = dp;
    e[342:327] = sp;
    e[351] = sp == dp;
    for (int i = 0; i < 8; i++) begin
      t = rtype[3*i+:3];
      e[343+i] = ((t == 3'h1 || t == 3'h3) && in_rng(sp, i))
        || ((t == 3'h2 || t == 3'h3) && in_rng(dp, i))
        || (t == 3'h4 && in_rng({4'h0, vid}, i))
        || (t == 3'h5 && in_rng({10'h0, dscp}, i));
    end
    if (tcp) begin
      e[352] = seq == 32'h0;
      e[358:353] = flags[5:0];
    end else if (ptp) begin
      e[355:352] = msg;
      e[358:356] = {fo[7], fo[2], fo[1]};
      e[366:359] = dom;
      e[370:367] = ver;
    end
    return e;
  endfunction : exp_key
endmodule : akb_src

//--- sim/tb_top.sv
// Purpose: Self-checking bench of the IPv6 transport key builder
// Assumes: One lookup strobe per cycle at most, key one cycle later
// Notes: Frame fields live in the stand-in model
`timescale 1ns/1ps
`include "akb_params.svh"
module tb_top;
  logic clock, rst, key_valid;
  logic [`AKB_KEY_W-1:0] key;
  int mismatches, tests_run;

  akb_src akb_src_i ();
  akb_top akb_top_i (.CLOCK(clock), .RST(rst), .LOOKUP_VALID(akb_src_i.lv),
    .FIRST_LOOKUP(akb_src_i.first), .POLICY_GROUP(akb_src_i.policy_group),
    .INGRESS_PORT(akb_src_i.port), .SRC_GUARD_HIT(akb_src_i.guard),
    .DEST_MAC(akb_src_i.dmac), .QTAG_COUNT(akb_src_i.qtags), .CLASS_VID(akb_src_i.vid),
    .CLASS_DEI(akb_src_i.dei), .CLASS_PCP(akb_src_i.pcp), .CLASS_DSCP(akb_src_i.dscp),
    .HOP_LIMIT(akb_src_i.hop), .TRAFFIC_CLASS(akb_src_i.tc),
    .IPV6_DEST_ADDR(akb_src_i.dip), .IPV6_SRC_ADDR(akb_src_i.sip),
    .NEXT_HEADER(akb_src_i.nh), .L4_DEST_PORT(akb_src_i.dp), .L4_SRC_PORT(akb_src_i.sp),
    .TCP_SEQ(akb_src_i.seq), .TCP_FLAGS(akb_src_i.flags), .IS_PTP(akb_src_i.ptp),
    .PTP_MSG_TYPE(akb_src_i.msg), .PTP_FLAG_OCTET(akb_src_i.fo),
    .PTP_DOMAIN(akb_src_i.dom), .PTP_VERSION(akb_src_i.ver),
    .RANGE_TYPE(akb_src_i.rtype), .RANGE_LOW(akb_src_i.rlo), .RANGE_HIGH(akb_src_i.rhi),
    .KEY(key), .KEY_VALID(key_valid));

  // ----------------------------------------
  // Checks and bus cycle
  // ----------------------------------------
  task automatic chk_key(input string what, input logic [`AKB_KEY_W-1:0] exp);
    tests_run++;
    if (key !== exp) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", what, exp, key);
    end
  endtask : chk_key

  task automatic chk_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s exp %b got %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic look(input string what);
    logic [`AKB_KEY_W-1:0] e;
    e = akb_src_i.exp_key();
    akb_src_i.lv = 1'b1;
    @(negedge clock);
    akb_src_i.lv = 1'b0;
    chk_bit({what, " valid"}, 1'b1, key_valid);
    chk_key(what, e);
    @(negedge clock);
    chk_bit({what, " pulse"}, 1'b0, key_valid);
    chk_key({what, " held"}, e);
  endtask : look

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_ports();
    for (int p = 0; p < 16; p++) begin
      akb_src_i.port = p[3:0];
      akb_src_i.first = p[0];
      akb_src_i.qtags = p[1:0];
      akb_src_i.guard = p[1];
      akb_src_i.policy_group = 8'h11 * p[7:0];
      akb_src_i.vid = 12'hFFF - p[11:0];
      akb_src_i.pcp = p[2:0];
      akb_src_i.dei = p[2];
      look("port");
    end
  endtask : t_ports

  task automatic t_mac();
    logic [47:0] macs [3];
    macs = '{48'h010000000001, 48'hFFFFFFFFFFFF, 48'hFEFFFFFFFFFF};
    for (int i = 0; i < 3; i++) begin
      akb_src_i.dmac = macs[i];
      akb_src_i.hop = i[7:0];
      akb_src_i.tc = 8'hC3 ^ i[7:0];
      akb_src_i.sip = (i == 1) ? akb_src_i.dip : akb_src_i.dip ^ 128'h1;
      look("mac");
    end
  endtask : t_mac

  task automatic t_l4();
    logic [7:0] nhs [6];
    nhs = '{8'h06, 8'h06, 8'h11, 8'h11, 8'h11, 8'h07};
    for (int i = 0; i < 6; i++) begin
      akb_src_i.nh = nhs[i];
      akb_src_i.ptp = i != 4;
      akb_src_i.seq = (i == 0) ? 32'h0 : 32'h1;
      akb_src_i.flags = (i == 0) ? 8'h2A : 8'hD5;
      akb_src_i.msg = (i == 2) ? 4'hA : 4'h5;
      akb_src_i.fo = (i == 2) ? 8'h86 : 8'h79;
      akb_src_i.sp = (i == 1) ? akb_src_i.dp : 16'h1F90;
      look("l4");
    end
  endtask : t_l4

  task automatic t_range();
    akb_src_i.nh = 8'h06;
    akb_src_i.rtype = {3'h7, 3'h6, 3'h0, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1};
    akb_src_i.rlo = {64'h0, 16'h0005, 16'h00C8, 16'h00C9, 16'h0064};
    akb_src_i.rhi = {48'hFFFFFFFFFFFF, 16'h0009, 16'h0005, 16'h00C8, 16'h012C, 16'h0064};
    akb_src_i.sp = 16'h0064;
    akb_src_i.dp = 16'h00C8;
    akb_src_i.vid = 12'h005;
    akb_src_i.dscp = 6'h0A;
    look("range lo");
    akb_src_i.sp = 16'h00C8;
    akb_src_i.dp = 16'h012C;
    akb_src_i.vid = 12'h006;
    akb_src_i.dscp = 6'h09;
    look("range hi");
  endtask : t_range

  task automatic t_b2b();
    logic [`AKB_KEY_W-1:0] ea, eb;
    akb_src_i.port = 4'h0;
    ea = akb_src_i.exp_key();
    akb_src_i.lv = 1'b1;
    @(negedge clock);
    akb_src_i.port = 4'hB;
    akb_src_i.first = ~akb_src_i.first;
    eb = akb_src_i.exp_key();
    chk_key("b2b a", ea);
    @(negedge clock);
    akb_src_i.lv = 1'b0;
    chk_bit("b2b valid", 1'b1, key_valid);
    chk_key("b2b b", eb);
    @(negedge clock);
  endtask : t_b2b

  task automatic t_reset();
    rst = 1'b1;
    akb_src_i.lv = 1'b1;
    @(negedge clock);
    akb_src_i.lv = 1'b0;
    chk_bit("rst valid", 1'b0, key_valid);
    chk_key("rst key", '0);
    rst = 1'b0;
    @(negedge clock);
  endtask : t_reset

  task automatic final_report();
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    #200000;
    mismatches++;
    final_report();
  end

  initial begin
    mismatches = 0;
    tests_run = 0;
    rst = 1'b1;
    repeat (20) @(negedge clock);
    chk_key("reset key", '0);
    rst = 1'b0;
    @(negedge clock);
    t_ports();
    t_mac();
    t_l4();
    t_range();
    t_b2b();
    t_reset();
    look("after reset");
    final_report();
  end
endmodule : tb_top
